/* File: verilog/video_fmt_consts.svh */
`ifndef VIDEO_FMT_CONSTS_SVH
`define VIDEO_FMT_CONSTS_SVH

// Register byte offsets
`define REG_CTRL 12'h000
`define REG_HSYNC 12'h004
`define REG_VSYNC_START 12'h008
`define REG_VSYNC_STOP 12'h00C
`define REG_VBLANK_START 12'h010
`define REG_VBLANK_STOP 12'h014
`define REG_STATUS 12'h018

// Control register field positions
`define CTRL_ENABLE_BIT 0
`define CTRL_MODE20_BIT 1
`define CTRL_EMBED_BIT 2
`define CTRL_STD625_BIT 3
`define CTRL_FIDPOL_BIT 4
`define CTRL_WIDTH 5

// Vertical edge registers: pixel in [9:0], line in [25:16]; HSYNC: start pixel in [9:0], stop pixel in [25:16]
`define EDGE_PIX_LSB 0
`define EDGE_LINE_LSB 16
`define STATUS_FIELD_BIT 26

// Reset values
`define CTRL_RESET 5'h00
`define HSYNC_RESET 32'h0320_02E0
`define VSYNC_START_RESET 32'h0004_0000
`define VSYNC_STOP_RESET 32'h0007_0000
`define VBLANK_START_RESET 32'h0001_0000
`define VBLANK_STOP_RESET 32'h0014_0000

// Line and pixel counts
`define PPL_525 10'h35A
`define PPL_625 10'h360
`define LPF_525 10'h20D
`define LPF_625 10'h271
`define ACTIVE_PIX 10'h2D0
`define FIELD_OFS_525 10'h107
`define FIELD_OFS_625 10'h139

// Field and vertical-blank flag boundaries (frame line numbers)
`define F0_FIRST_525 10'h004
`define F0_LAST_525 10'h109
`define V1_LAST_525 10'h013
`define V2_FIRST_525 10'h108
`define V2_LAST_525 10'h11A
`define F1_FIRST_625 10'h139
`define V1_LAST_625 10'h016
`define V2_FIRST_625 10'h137
`define V2_LAST_625 10'h14F
`define V3_FIRST_625 10'h270

// Fixed code and blanking words
`define WORD_ONES 10'h3FF
`define WORD_ZERO 10'h000
`define BLANK_Y 10'h040
`define BLANK_C 10'h200

`endif

/* File: verilog/video_fmt_pkg.sv */
package video_fmt_pkg;

    typedef struct packed {
        logic [9:0] y;
        logic [9:0] c;
    } pixel_t;

    typedef struct packed {
        logic field_pol;
        logic std625;
        logic embedded;
        logic mode20;
        logic enable;
    } ctrl_t;

    typedef struct packed {
        logic [9:0] luma;
        logic [9:0] chroma;
    } out_bus_t;

endpackage

/* File: verilog/timing_code_word.sv */
`timescale 1ns/100ps
`include "video_fmt_consts.svh"

module timing_code_word
(
    input wire logic f,
    input wire logic v,
    input wire logic h,
    input wire logic [1:0] idx,
    output logic [9:0] word
);

    wire logic [3:0] prot;
    wire logic [9:0] status;

    assign prot = {v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    assign status = {1'b1, f, v, h, prot, 2'b00};
    assign word = (idx == 2'd0) ? `WORD_ONES :
                  (idx == 2'd3) ? status : `WORD_ZERO;

endmodule // timing_code_word

/* File: verilog/video_output_formatter.sv */
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "video_fmt_consts.svh"

module video_output_formatter
    import video_fmt_pkg::*;
#(
    parameter int PIX_W = 10
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pixel_t comp_pixel,
    input wire pixel_t rgb_pixel,
    input wire logic fast_switch_pin,
    output logic pixel_strobe,
    output out_bus_t video_bus,
    output logic pixel_output_clock,
    output logic horizontal_sync_out,
    output logic vertical_sync_out,
    output logic vertical_blank_out,
    output logic field_ident_out,
    output logic active_video_window
);

    generate
        if (PIX_W != 10)
        begin : g_width_check
            $error("Only 10-bit pixel words are supported");
        end
    endgenerate

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Vertical edge hit in either field; field two sits a field later
    function automatic logic edge_hit(input logic [31:0] edge_v,
                                      input logic [9:0] line,
                                      input logic [9:0] pix,
                                      input logic [9:0] ofs);
        logic [9:0] l;
        l = edge_v[`EDGE_LINE_LSB +: 10];
        return (pix == edge_v[`EDGE_PIX_LSB +: 10]) &&
               ((line == l) || (line == l + ofs));
    endfunction

    ctrl_t ctrl_q;
    logic [31:0] hsync_reg_q;
    logic [31:0] vstart_q;
    logic [31:0] vstop_q;
    logic [31:0] vb_start_q;
    logic [31:0] vb_stop_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    logic fs_s1_q;
    logic fs_s2_q;
    logic clk_q;
    logic [9:0] pix_q;
    logic sub_q;
    logic [9:0] line_q;
    logic strobe_q;
    pixel_t hold_q;
    out_bus_t bus_q;
    logic hsync_q;
    logic vsync_q;
    logic vblank_q;
    logic field_q;
    logic field_out_q;
    logic window_q;

    // APB decode
    wire logic setup = psel && !penable;
    wire logic wr_done = psel && penable && pready_q && pwrite;
    wire logic sel_ctrl = (paddr == `REG_CTRL);
    wire logic sel_hsync = (paddr == `REG_HSYNC);
    wire logic sel_vss = (paddr == `REG_VSYNC_START);
    wire logic sel_vse = (paddr == `REG_VSYNC_STOP);
    wire logic sel_vbs = (paddr == `REG_VBLANK_START);
    wire logic sel_vbe = (paddr == `REG_VBLANK_STOP);
    wire logic sel_st = (paddr == `REG_STATUS);
    wire logic mapped = sel_ctrl || sel_hsync || sel_vss || sel_vse ||
                        sel_vbs || sel_vbe || sel_st;
    wire logic [31:0] ctrl_word = {27'd0, ctrl_q};
    wire logic [31:0] status_word = {5'd0, field_q, line_q, 6'd0, pix_q};
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (sel_ctrl)
            rd_mux = ctrl_word;
        else if (sel_hsync)
            rd_mux = hsync_reg_q;
        else if (sel_vss)
            rd_mux = vstart_q;
        else if (sel_vse)
            rd_mux = vstop_q;
        else if (sel_vbs)
            rd_mux = vb_start_q;
        else if (sel_vbe)
            rd_mux = vb_stop_q;
        else if (sel_st)
            rd_mux = status_word;
    end

    wire logic [31:0] ctrl_new = merge_bytes(ctrl_word, pwdata, pstrb);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= setup && !mapped;
            if (setup && !pwrite)
                prdata_q <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= `CTRL_RESET;
            hsync_reg_q <= `HSYNC_RESET;
            vstart_q <= `VSYNC_START_RESET;
            vstop_q <= `VSYNC_STOP_RESET;
            vb_start_q <= `VBLANK_START_RESET;
            vb_stop_q <= `VBLANK_STOP_RESET;
        end
        else if (wr_done)
        begin
            if (sel_ctrl)
                ctrl_q <= ctrl_new[`CTRL_WIDTH-1:0];
            if (sel_hsync)
                hsync_reg_q <= merge_bytes(hsync_reg_q, pwdata, pstrb);
            if (sel_vss)
                vstart_q <= merge_bytes(vstart_q, pwdata, pstrb);
            if (sel_vse)
                vstop_q <= merge_bytes(vstop_q, pwdata, pstrb);
            if (sel_vbs)
                vb_start_q <= merge_bytes(vb_start_q, pwdata, pstrb);
            if (sel_vbe)
                vb_stop_q <= merge_bytes(vb_stop_q, pwdata, pstrb);
        end
    end

    // Standard-dependent geometry
    wire logic [9:0] ppl = ctrl_q.std625 ? `PPL_625 : `PPL_525;
    wire logic [9:0] lpf = ctrl_q.std625 ? `LPF_625 : `LPF_525;
    wire logic [9:0] fofs = ctrl_q.std625 ? `FIELD_OFS_625 : `FIELD_OFS_525;
    wire logic [9:0] ppl_m1 = ppl - 10'd1;
    wire logic [9:0] ppl_m2 = ppl - 10'd2;

    // Output clock: data changes as it falls, the consumer samples on rise
    wire logic word_en = clk_q && ctrl_q.enable;
    wire logic last_sub = ctrl_q.mode20 || sub_q;
    wire logic wrap_pix = last_sub && (pix_q == ppl_m1);
    wire logic [9:0] nxt_pix = !last_sub ? pix_q :
                               wrap_pix ? 10'd0 : pix_q + 10'd1;
    wire logic nxt_sub = !last_sub;
    wire logic [9:0] nxt_line = !wrap_pix ? line_q :
                                (line_q == lpf) ? 10'd1 : line_q + 10'd1;

    // Field and vertical flags per standard
    wire logic f525 = !((line_q >= `F0_FIRST_525) &&
                        (line_q <= `F0_LAST_525));
    wire logic v525 = (line_q <= `V1_LAST_525) ||
                      ((line_q >= `V2_FIRST_525) &&
                       (line_q <= `V2_LAST_525));
    wire logic f625 = (line_q >= `F1_FIRST_625);
    wire logic v625 = (line_q <= `V1_LAST_625) ||
                      ((line_q >= `V2_FIRST_625) &&
                       (line_q <= `V2_LAST_625)) ||
                      (line_q >= `V3_FIRST_625);
    wire logic f_bit = ctrl_q.std625 ? f625 : f525;
    wire logic v_bit = ctrl_q.std625 ? v625 : v525;

    // Position classification for the word now due
    wire logic active_now = (pix_q < `ACTIVE_PIX);
    wire logic codes_on = ctrl_q.embedded && !ctrl_q.mode20;
    wire logic eav_zone = codes_on && ((pix_q == `ACTIVE_PIX) ||
                          (pix_q == `ACTIVE_PIX + 10'd1));
    wire logic sav_zone = codes_on && ((pix_q == ppl_m2) ||
                          (pix_q == ppl_m1));
    // Both zones start on an even pixel, so bit 0 orders the pixel pair
    wire logic [1:0] code_idx = {pix_q[0], sub_q};
    wire logic [9:0] code_word;

    timing_code_word u_code
    (
        .f(f_bit),
        .v(v_bit),
        .h(eav_zone),
        .idx(code_idx),
        .word(code_word)
    );

    // Chroma goes first in each pixel, so a pair reads Cb, Y, Cr, Y
    wire logic [9:0] mux10_act = sub_q ? hold_q.y : hold_q.c;
    wire logic [9:0] mux10_blk = sub_q ? `BLANK_Y : `BLANK_C;
    wire logic [9:0] luma10 = (eav_zone || sav_zone) ? code_word :
                              active_now ? mux10_act : mux10_blk;
    wire logic [9:0] luma20 = active_now ? hold_q.y : `BLANK_Y;
    wire logic [9:0] chroma20 = active_now ? hold_q.c : `BLANK_C;
    wire out_bus_t bus_d = ctrl_q.mode20 ?
                           out_bus_t'{luma: luma20, chroma: chroma20} :
                           out_bus_t'{luma: luma10, chroma: `WORD_ZERO};
    wire logic window_d = active_now ||
                        (ctrl_q.mode20 && (pix_q >= ppl_m2));

    // Edge events, evaluated once per pixel
    wire logic px_edge = word_en && !sub_q;
    wire logic hsync_set = px_edge && (pix_q == hsync_reg_q[9:0]);
    wire logic hsync_clr = px_edge && (pix_q == hsync_reg_q[25:16]);
    wire logic vsync_set = px_edge && edge_hit(vstart_q, line_q, pix_q, fofs);
    wire logic vsync_clr = px_edge && edge_hit(vstop_q, line_q, pix_q, fofs);
    wire logic vb_on = px_edge && edge_hit(vb_start_q, line_q, pix_q, fofs);
    wire logic vb_off = px_edge && edge_hit(vb_stop_q, line_q, pix_q, fofs);
    wire logic need_pix = word_en && !nxt_sub && (nxt_pix < `ACTIVE_PIX);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fs_s1_q <= 1'b0;
            fs_s2_q <= 1'b0;
        end
        else
        begin
            fs_s1_q <= fast_switch_pin;
            fs_s2_q <= fs_s1_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clk_q <= 1'b0;
        else
            clk_q <= ctrl_q.enable ? !clk_q : 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pix_q <= 10'd0;
            sub_q <= 1'b0;
            line_q <= 10'd1;
        end
        else if (!ctrl_q.enable)
        begin
            pix_q <= 10'd0;
            sub_q <= 1'b0;
            line_q <= 10'd1;
        end
        else if (word_en)
        begin
            pix_q <= nxt_pix;
            sub_q <= nxt_sub;
            line_q <= nxt_line;
        end
    end

    // Capture one cycle after the request, ahead of the word that needs it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strobe_q <= 1'b0;
            hold_q <= '0;
        end
        else
        begin
            strobe_q <= need_pix;
            if (strobe_q)
                hold_q <= fs_s2_q ? rgb_pixel : comp_pixel;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_q <= '{luma: `BLANK_Y, chroma: `WORD_ZERO};
            window_q <= 1'b0;
        end
        else if (word_en)
        begin
            bus_q <= bus_d;
            window_q <= window_d;
        end
    end

    // A start and stop on the same pixel leaves the output low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hsync_q <= 1'b0;
            vsync_q <= 1'b0;
            vblank_q <= 1'b0;
            field_q <= 1'b0;
        end
        else
        begin
            if (hsync_clr)
                hsync_q <= 1'b0;
            else if (hsync_set)
                hsync_q <= 1'b1;
            if (vsync_clr)
                vsync_q <= 1'b0;
            else if (vsync_set)
                vsync_q <= 1'b1;
            if (vb_off)
                vblank_q <= 1'b0;
            else if (vb_on)
                vblank_q <= 1'b1;
            if (vsync_clr)
                field_q <= !field_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            field_out_q <= 1'b0;
        else
            field_out_q <= (vsync_clr ? !field_q : field_q) ^
                           ctrl_q.field_pol;
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pixel_strobe = strobe_q;
    assign video_bus = bus_q;
    assign pixel_output_clock = clk_q;
    assign horizontal_sync_out = hsync_q;
    assign vertical_sync_out = vsync_q;
    assign vertical_blank_out = vblank_q;
    assign field_ident_out = field_out_q;
    assign active_video_window = window_q;

endmodule // video_output_formatter

/* File: test/formatter_checker.sv */
`timescale 1ns/100ps
module formatter_checker
    import video_fmt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pixel_strobe,
    input wire out_bus_t video_bus,
    input wire logic pixel_output_clock,
    input wire logic horizontal_sync_out,
    input wire logic vertical_sync_out,
    input wire logic field_ident_out,
    input wire logic active_video_window
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic [9:0] lw = video_bus.luma;
    // Pixel data never reaches all-ones, so 3FF can only open a code
    wire logic code_ok = lw[9] && lw[1:0] == 2'h0
        && lw[5] == (lw[7] ^ lw[6]) && lw[4] == (lw[8] ^ lw[6])
        && lw[3] == (lw[8] ^ lw[7]) && lw[2] == (^lw[8:6]);

    ready_after_setup_a:
    assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_pulse_a:
    assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    error_with_ready_a:
    assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    clock_half_a:
    assert property (pixel_output_clock |=> !pixel_output_clock)
        else $error("data clock high too long");
    bus_at_fall_a:
    assert property ($changed(video_bus) |-> $fell(pixel_output_clock))
        else $error("bus changed off the clock fall");
    sync_at_fall_a:
    assert property ($changed({horizontal_sync_out, vertical_sync_out,
        active_video_window}) |-> $fell(pixel_output_clock))
        else $error("sync changed off the clock fall");
    fid_toggle_a:
    assert property ($fell(vertical_sync_out) |-> $changed(field_ident_out))
        else $error("field ident did not toggle");
    code_seq_a:
    assert property ($fell(pixel_output_clock) && lw == 10'h3FF
        |-> ##2 lw == 10'h000 ##2 lw == 10'h000 ##2 code_ok)
        else $error("timing code malformed");
    strobe_pulse_a:
    assert property (pixel_strobe |=> !pixel_strobe)
        else $error("capture strobe too long");
endmodule // formatter_checker

bind video_output_formatter formatter_checker u_formatter_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .pixel_strobe(pixel_strobe),
    .video_bus(video_bus), .pixel_output_clock(pixel_output_clock),
    .horizontal_sync_out(horizontal_sync_out),
    .vertical_sync_out(vertical_sync_out),
    .field_ident_out(field_ident_out),
    .active_video_window(active_video_window)
);

/* File: test/video_sink.sv */
`timescale 1ns/100ps
module video_sink
    import video_fmt_pkg::*;
(
    input wire logic pixel_output_clock,
    input wire out_bus_t video_bus,
    input wire logic active_video_window
);
    out_bus_t act [$];
    logic [9:0] last_luma = 10'h000;
    logic [9:0] sav_word = 10'h000;
    logic [9:0] eav_word = 10'h000;
    logic window_q = 1'b0;
    int clk_n = 0;
    int per_line = 0;
    int post_n = 8;
    // Rising data clock lands mid-word, as a real back end latches it
    always @(posedge pixel_output_clock)
    begin
        clk_n++;
        post_n++;
        if (active_video_window && !window_q)
        begin
            act.delete();
            sav_word = last_luma;
            per_line = clk_n;
            clk_n = 0;
        end
        if (window_q && !active_video_window)
            post_n = 0;
        if (post_n == 3)
            eav_word = video_bus.luma;
        if (active_video_window)
            act.push_back(video_bus);
        window_q = active_video_window;
        last_luma = video_bus.luma;
    end
endmodule // video_sink

/* File: test/testbench.sv */
`timescale 1ns/100ps
`include "video_fmt_consts.svh"
module testbench;
    import video_fmt_pkg::*;
    typedef struct {
        logic m20, emb, s625, fs, pol;
        int hw, clks, actn;
        logic [9:0] sav, eav;
    } row_t;
    // 20-bit rows ask for codes too: they must be refused there
    row_t rows [4] = '{
        '{0, 1, 0, 0, 0, 64, 1716, 1440, 10'h3B0, 10'h3C4},
        '{0, 1, 1, 1, 1, 1, 1728, 1440, 10'h2AC, 10'h2D8},
        '{1, 1, 0, 1, 1, 100, 858, 722, 10'h040, 10'h040},
        '{1, 1, 1, 0, 0, 20, 864, 722, 10'h040, 10'h040}
    };
    row_t row;
    logic pclk, presetn, psel, penable, pwrite, fast_switch_pin, err;
    logic par = 1'b1;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic pready, pslverr, pixel_strobe, pixel_output_clock;
    logic horizontal_sync_out, vertical_sync_out, vertical_blank_out;
    logic field_ident_out, active_video_window;
    logic [9:0] y, cb, cr;
    pixel_t comp_pixel, rgb_pixel;
    out_bus_t video_bus;
    int miscompares = 0;
    int cmp_count = 0;
    int hsync_run = 0;
    int hsync_w = 0;
    int vsync_cnt = 0;

    video_output_formatter u_video_output_formatter (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comp_pixel(comp_pixel),
        .rgb_pixel(rgb_pixel), .fast_switch_pin(fast_switch_pin),
        .pixel_strobe(pixel_strobe), .video_bus(video_bus),
        .pixel_output_clock(pixel_output_clock),
        .horizontal_sync_out(horizontal_sync_out),
        .vertical_sync_out(vertical_sync_out),
        .vertical_blank_out(vertical_blank_out),
        .field_ident_out(field_ident_out),
        .active_video_window(active_video_window)
    );
    video_sink u_video_sink (
        .pixel_output_clock(pixel_output_clock), .video_bus(video_bus),
        .active_video_window(active_video_window)
    );

    // Both sources step together on the one capture strobe
    assign comp_pixel = '{y: 10'h111, c: par ? 10'h133 : 10'h122};
    assign rgb_pixel = '{y: 10'h244, c: par ? 10'h266 : 10'h255};
    // First line after enable captures from pixel 1 (odd), so start on Cr
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            par <= 1'b1;
        else if (pixel_strobe)
            par <= ~par;
    always @(negedge pclk)
    begin
        vsync_cnt <= presetn ? vsync_cnt + int'(vertical_sync_out) : 0;
        hsync_run <= horizontal_sync_out ? hsync_run + 1 : 0;
        if (!horizontal_sync_out && hsync_run != 0)
            hsync_w <= hsync_run;
    end
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("Compared %0d, mismatched %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 20)
        begin
            miscompares++;
            stop_test();
        end
    endtask
    task automatic wait_falls(input int n);
        int k;
        logic p;
        k = 0;
        p = 1'b0;
        for (int i = 0; i < 4000 * n && k < n; i++)
        begin
            @(negedge pclk);
            if (p && !active_video_window)
                k++;
            p = active_video_window;
        end
        if (k < n)
        begin
            miscompares++;
            stop_test();
        end
    endtask
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        fast_switch_pin = 1'b0;
        for (int r = 0; r < 4; r++)
        begin
            row = rows[r];
            do_reset();
            fast_switch_pin <= row.fs;
            apb(1'b1, `REG_HSYNC, {6'h00, 10'h2E4 + 10'(row.hw), 6'h00,
                10'h2E4}, 4'hF);
            apb(1'b1, `REG_VSYNC_START, 32'h0002_0000, 4'hF);
            apb(1'b1, `REG_VSYNC_STOP, 32'h0003_0000, 4'hF);
            apb(1'b1, `REG_CTRL, {27'h0, row.pol, row.s625, row.emb,
                row.m20, 1'b1}, 4'hF);
            wait_falls(3);
            y = row.fs ? 10'h244 : 10'h111;
            cb = row.fs ? 10'h255 : 10'h122;
            cr = row.fs ? 10'h266 : 10'h133;
            chk("line clocks", row.clks, u_video_sink.per_line);
            chk("window words", row.actn, u_video_sink.act.size());
            if (row.m20)
            begin
                chk("pixel 2", {y, cb}, u_video_sink.act[4]);
                chk("pixel 3", {y, cr}, u_video_sink.act[5]);
            end
            else
            begin
                chk("word 4", {cb, 10'h000}, u_video_sink.act[4]);
                chk("word 5", {y, 10'h000}, u_video_sink.act[5]);
                chk("word 6", {cr, 10'h000}, u_video_sink.act[6]);
                chk("word 7", {y, 10'h000}, u_video_sink.act[7]);
            end
            chk("start code", row.sav, u_video_sink.sav_word);
            chk("end code", row.eav, u_video_sink.eav_word);
            chk("vsync clocks", 2 * row.clks, vsync_cnt);
            chk("hsync clocks", row.hw * (row.m20 ? 2 : 4), hsync_w);
            chk("field ident", !row.pol, field_ident_out);
            chk("vblank", 1'b1, vertical_blank_out);
            $display("Row %0d done", r);
        end
        do_reset();
        apb(1'b0, `REG_CTRL, 32'h0, 4'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, `REG_HSYNC, 32'h0, 4'h0);
        chk("hsync reset", `HSYNC_RESET, rd);
        apb(1'b1, `REG_VSYNC_START, 32'h00AB_CDEF, 4'h4);
        apb(1'b0, `REG_VSYNC_START, 32'h0, 4'h0);
        chk("byte strobe", 32'h00AB_0000, rd);
        apb(1'b0, 12'h01C, 32'h0, 4'h0);
        chk("unmapped error", 1'b1, err);
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, `REG_STATUS, 32'hFFFF_FFFF, 4'hF);
        chk("status write", 1'b0, err);
        $display("Register test done");
        stop_test();
    end
endmodule // testbench
